// file: hdl/rdb_dma_regs.sv
/*
 Receive DMA result registers: start offset, frame count, byte count.
 Assumes one completed-frame pulse per frame moved to host memory.
*/
`timescale 1ns/100ps
module rdb_dma_regs (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Frame moved to host
    input wire logic i_frame_done,
    input wire logic [15:0] i_frame_len,
    // Publish and host read of frame count
    input wire logic i_publish,
    input wire logic i_count_read,
    // Visible registers
    output logic [15:0] o_start_offset,
    output logic [15:0] o_frame_count,
    output logic [15:0] o_byte_count
);
    logic [15:0] acc_frames;
    logic [15:0] acc_bytes;
    logic [15:0] wr_ptr;

    function automatic logic [15:0] dword_align(input logic [15:0] v);
        dword_align = (v + 16'h0003) & 16'hfffc;
    endfunction

    // Count frames until published, keep the last frame length; a read empties the visible count unless a publish comes in the same cycle
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            acc_frames <= 16'h0000;
            acc_bytes <= 16'h0000;
            wr_ptr <= 16'h0000;
            o_start_offset <= 16'h0000;
            o_frame_count <= 16'h0000;
            o_byte_count <= 16'h0000;
        end else begin
            if (i_frame_done) begin
                acc_frames <= acc_frames + 16'h0001;
                acc_bytes <= i_frame_len;
                wr_ptr <= wr_ptr + dword_align(i_frame_len);
                o_start_offset <= wr_ptr;
            end
            if (i_publish) begin
                o_frame_count <= o_frame_count + acc_frames
                                 + {15'h0000, i_frame_done};
                o_byte_count <= i_frame_done ? i_frame_len : acc_bytes;
                acc_frames <= 16'h0000;
            end else if (i_count_read) begin
                o_frame_count <= 16'h0000;
            end
        end
    end
endmodule // rdb_dma_regs

// file: hdl/rdb_gap_timer.sv
/*
 Measures spacing between frame ends and classifies it as back-to-back.
 Assumes frame-end pulses are synchronous to i_clock.
*/
`timescale 1ns/100ps
`include "rdb_map.svh"
module rdb_gap_timer
    import rdb_pkg::*;
#(
    parameter int MIN_CYC = `RDB_GAP_MIN_CYC,
    parameter int MAX_CYC = `RDB_GAP_MAX_CYC
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Frame end event
    input wire logic i_frame_end,
    // Spacing verdict, valid with i_frame_end
    output logic o_back_to_back
);
    logic [15:0] gap_count;
    logic seen;

    // Saturate so an idle line never wraps into the window
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || i_frame_end) begin
            gap_count <= 16'h0000;
        end else if (gap_count != 16'hffff) begin
            gap_count <= gap_count + 16'h0001;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            seen <= 1'b0;
        end else if (i_frame_end) begin
            seen <= 1'b1;
        end
    end

    assign o_back_to_back = seen && (gap_count >= 16'(MIN_CYC))
                            && (gap_count <= 16'(MAX_CYC));
endmodule // rdb_gap_timer

// file: hdl/rdb_map.svh
/*
 Register offsets, bit positions and timing counts for the receive DMA
 mode and burst control block. Included by the package and modules.
*/
`ifndef RDB_MAP_SVH
`define RDB_MAP_SVH
// Register indices on the internal register port
`define RDB_OFF_RX_CFG 16'h0102
`define RDB_OFF_RX_CTL 16'h0104
`define RDB_OFF_BUF_CFG 16'h010a
`define RDB_OFF_BUF_EVENT 16'h010c
`define RDB_OFF_MISSED 16'h0130
`define RDB_OFF_DMA_SOF 16'h0026
`define RDB_OFF_DMA_FCNT 16'h0028
`define RDB_OFF_DMA_BCNT 16'h002a
// Receive configuration bits
`define RDB_BIT_BURST_EN 7
`define RDB_BIT_GOOD_IE 8
`define RDB_BIT_DMA_ONLY 9
`define RDB_BIT_AUTO_DMA 10
// Receive control bits
`define RDB_BIT_ACCEPT_GOOD 8
// Buffer configuration bits
`define RDB_BIT_DMA_IE 7
`define RDB_BIT_B128_IE 11
`define RDB_BIT_DEST_IE 15
// Buffer event bits
`define RDB_BIT_DMA_FLAG 7
// Reset values
`define RDB_RST_CFG 16'h0000
// Burst spacing in ns and in clock cycles, burst cycle length in frames
`define RDB_GAP_MIN_NS 9600
`define RDB_GAP_MAX_NS 52000
`define RDB_CLK_NS 8
`define RDB_GAP_MIN_CYC ((`RDB_GAP_MIN_NS + `RDB_CLK_NS - 1) / `RDB_CLK_NS)
`define RDB_GAP_MAX_CYC (`RDB_GAP_MAX_NS / `RDB_CLK_NS)
`define RDB_BURST_MAX 8
`endif

// file: hdl/rdb_pkg.sv
/*
 Types for the receive DMA mode and burst control block.
 Assumes rdb_map.svh is on the include path.
*/
package rdb_pkg;
    `include "rdb_map.svh"

    typedef enum logic [1:0] {
        RDB_MODE_PIO = 2'b00,
        RDB_MODE_AUTO = 2'b01,
        RDB_MODE_DMA_ONLY = 2'b10
    } rdb_mode_e;

    typedef enum logic [2:0] {
        RDB_ST_IDLE = 3'b000,
        RDB_ST_XFER = 3'b001,
        RDB_ST_HOLD = 3'b010,
        RDB_ST_BURST = 3'b011,
        RDB_ST_BEND = 3'b100
    } rdb_state_e;

    // One received frame status, from the MAC
    typedef struct packed {
        logic addr_pass;
        logic good;
        logic [15:0] length;
    } rdb_frame_s;

    // Register port request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } rdb_reg_req_s;
endpackage

// file: hdl/rdb_rx_dma_ctrl.sv
/*
 Receive DMA mode selection, DMA exit and burst grouping control.
 Assumes a MAC reporting frame status, a buffer manager reporting space,
 and a DMA mover signalling frame completion, all on i_clock.
*/
`timescale 1ns/100ps
`include "rdb_map.svh"
module rdb_rx_dma_ctrl
    import rdb_pkg::*;
#(
    parameter int BURST_MAX = `RDB_BURST_MAX
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Register port
    input rdb_reg_req_s i_reg,
    output logic [15:0] o_rdata,
    // MAC frame status
    input wire logic i_frame_end,
    input rdb_frame_s i_frame,
    input wire logic i_frame_start,
    input wire logic i_start_addr_pass,
    input wire logic i_frame_missed,
    // Buffer manager
    input wire logic i_space_low,
    input wire logic i_frames_buffered,
    input wire logic i_reports_pending,
    // DMA mover
    input wire logic i_dma_frame_done,
    input wire logic [15:0] i_dma_frame_len,
    input wire logic i_dma_busy,
    // Control outputs
    output logic o_dma_active,
    output logic o_free_oldest,
    output logic o_discard_rx_reports,
    output logic o_drop_missed_reports,
    output logic o_good_irq,
    output logic o_dma_irq,
    output logic o_pio_frame
);
    logic [15:0] rx_cfg;
    logic [15:0] rx_ctl;
    logic [15:0] buf_cfg;
    logic [15:0] missed_frame_counter;
    logic dma_frame_flag;
    logic count_zero_read;
    logic [3:0] burst_count;
    logic first_held;
    logic publish;
    logic b2b;
    logic b2b_q;
    logic frame_ok;
    logic burst_allowed;
    logic [15:0] start_offset;
    logic [15:0] frame_count;
    logic [15:0] byte_count;
    rdb_state_e state;
    rdb_state_e next_state;
    rdb_mode_e mode;

    rdb_gap_timer u_gap (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_frame_end(i_frame_end),
        .o_back_to_back(b2b)
    );

    rdb_dma_regs u_regs (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_frame_done(i_dma_frame_done),
        .i_frame_len(i_dma_frame_len),
        .i_publish(publish),
        .i_count_read(i_reg.rd && i_reg.addr == `RDB_OFF_DMA_FCNT),
        .o_start_offset(start_offset),
        .o_frame_count(frame_count),
        .o_byte_count(byte_count)
    );

    always_comb begin
        if (rx_cfg[`RDB_BIT_DMA_ONLY]) begin
            mode = RDB_MODE_DMA_ONLY;
        end else if (rx_cfg[`RDB_BIT_AUTO_DMA]) begin
            mode = RDB_MODE_AUTO;
        end else begin
            mode = RDB_MODE_PIO;
        end
    end

    assign frame_ok = i_frame.addr_pass && i_frame.good;
    assign burst_allowed = rx_cfg[`RDB_BIT_BURST_EN]
        && (mode != RDB_MODE_PIO)
        && rx_ctl[`RDB_BIT_ACCEPT_GOOD] && rx_cfg[`RDB_BIT_GOOD_IE]
        && !buf_cfg[`RDB_BIT_DEST_IE] && !buf_cfg[`RDB_BIT_B128_IE];

    // Configuration registers
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            rx_cfg <= `RDB_RST_CFG;
            rx_ctl <= `RDB_RST_CFG;
            buf_cfg <= `RDB_RST_CFG;
        end else if (i_reg.wr) begin
            if (i_reg.addr == `RDB_OFF_RX_CFG) begin
                rx_cfg <= i_reg.wdata;
            end else if (i_reg.addr == `RDB_OFF_RX_CTL) begin
                rx_ctl <= i_reg.wdata;
            end else if (i_reg.addr == `RDB_OFF_BUF_CFG) begin
                buf_cfg <= i_reg.wdata;
            end
        end
    end

    // Missed frame counting, read clears; miss wins
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            missed_frame_counter <= 16'h0000;
        end else if (i_frame_missed) begin
            missed_frame_counter <= (i_reg.rd
                && i_reg.addr == `RDB_OFF_MISSED) ? 16'h0001
                : missed_frame_counter + 16'h0001;
        end else if (i_reg.rd && i_reg.addr == `RDB_OFF_MISSED) begin
            missed_frame_counter <= 16'h0000;
        end
    end

    // Zero frame count read seen by host
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || state == RDB_ST_IDLE) begin
            count_zero_read <= 1'b0;
        end else if (publish) begin
            // New frames outrank a read in the same cycle
            count_zero_read <= 1'b0;
        end else if (i_reg.rd && i_reg.addr == `RDB_OFF_DMA_FCNT) begin
            count_zero_read <= (frame_count == 16'h0000);
        end
    end

    // State machine
    always_comb begin
        next_state = state;
        case (state)
            RDB_ST_IDLE: begin
                // Burst start on a good frame inside the spacing window after the previous frame end
                if (burst_allowed && i_frame_end && frame_ok && b2b) begin
                    next_state = RDB_ST_BURST;
                end else if (mode == RDB_MODE_DMA_ONLY
                             && i_frames_buffered) begin
                    next_state = RDB_ST_XFER;
                end else if (mode == RDB_MODE_AUTO && i_frame_start
                             && i_space_low && i_start_addr_pass
                             && i_frames_buffered) begin
                    next_state = RDB_ST_XFER;
                end
            end
            RDB_ST_XFER: begin
                if (!i_dma_busy && !i_frames_buffered) begin
                    next_state = RDB_ST_HOLD;
                end
            end
            RDB_ST_HOLD: begin
                // Leave DMA on all exit conditions
                if (i_frames_buffered) begin
                    next_state = RDB_ST_XFER;
                end else if (!i_reports_pending && count_zero_read
                             && !i_dma_busy) begin
                    next_state = RDB_ST_IDLE;
                end
            end
            RDB_ST_BURST: begin
                // End on failed frame or 52 us silence
                if ((i_frame_end && !(frame_ok && b2b))
                    || (b2b_q && !b2b)) begin
                    next_state = RDB_ST_BEND;
                end
            end
            RDB_ST_BEND: begin
                if (!i_dma_busy) begin
                    next_state = RDB_ST_HOLD;
                end
            end
            default: next_state = RDB_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            state <= RDB_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Frames moved in this burst cycle
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || state != RDB_ST_BURST
            || burst_count == 4'(BURST_MAX)) begin
            burst_count <= 4'h0;
        end else if (i_dma_frame_done) begin
            burst_count <= burst_count + 4'h1;
        end
    end

    // Spacing window closed with no frame in it
    always_ff @(posedge i_clock) begin
        b2b_q <= !i_sys_rst && b2b && !i_frame_end;
    end

    // Publish at end of each burst cycle, and on each moved frame outside a burst
    assign publish = (state == RDB_ST_BURST
                      && burst_count == 4'(BURST_MAX))
        || (state == RDB_ST_BEND && !i_dma_busy)
        || (state != RDB_ST_BURST && state != RDB_ST_BEND
            && i_dma_frame_done);

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            dma_frame_flag <= 1'b0;
        end else begin
            dma_frame_flag <= publish || (frame_count != 16'h0000);
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst || state != RDB_ST_IDLE || !burst_allowed) begin
            first_held <= 1'b0;
        end else if (i_frame_end) begin
            first_held <= frame_ok && rx_cfg[`RDB_BIT_GOOD_IE]
                && mode != RDB_MODE_DMA_ONLY && next_state == RDB_ST_IDLE;
        end else if (b2b_q && !b2b) begin
            first_held <= 1'b0;
        end
    end

    // Interrupt pulses
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_good_irq <= 1'b0;
            o_dma_irq <= 1'b0;
        end else begin
            o_good_irq <= (state == RDB_ST_BEND && !i_dma_busy)
                || (first_held && ((b2b_q && !b2b)
                    || (i_frame_end && next_state == RDB_ST_IDLE)))
                || (state == RDB_ST_IDLE && mode != RDB_MODE_DMA_ONLY
                    && i_frame_end && frame_ok && !burst_allowed
                    && rx_cfg[`RDB_BIT_GOOD_IE]
                    && next_state == RDB_ST_IDLE);
            o_dma_irq <= publish && (buf_cfg[`RDB_BIT_DMA_IE]
                || (state == RDB_ST_BEND));
        end
    end

    // Status outputs
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_dma_active <= 1'b0;
            o_free_oldest <= 1'b0;
            o_discard_rx_reports <= 1'b0;
            o_drop_missed_reports <= 1'b0;
            o_pio_frame <= 1'b0;
        end else begin
            // No DMA in PIO mode
            o_dma_active <= (next_state != RDB_ST_IDLE)
                && (mode != RDB_MODE_PIO);
            // Free only after a whole frame moved
            o_free_oldest <= i_dma_frame_done;
            o_discard_rx_reports <= (state == RDB_ST_IDLE)
                && (next_state != RDB_ST_IDLE);
            // Drop reports of the missed frame
            o_drop_missed_reports <= i_frame_missed;
            o_pio_frame <= (state == RDB_ST_IDLE) && i_frame_end
                && (next_state == RDB_ST_IDLE)
                && (mode != RDB_MODE_DMA_ONLY);
        end
    end

    // Read data, registered
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || !i_reg.rd) begin
            o_rdata <= 16'h0000;
        end else if (i_reg.addr == `RDB_OFF_RX_CFG) begin
            o_rdata <= rx_cfg;
        end else if (i_reg.addr == `RDB_OFF_RX_CTL) begin
            o_rdata <= rx_ctl;
        end else if (i_reg.addr == `RDB_OFF_BUF_CFG) begin
            o_rdata <= buf_cfg;
        end else if (i_reg.addr == `RDB_OFF_BUF_EVENT) begin
            // Reading does not clear the flag
            o_rdata <= 16'(dma_frame_flag) << `RDB_BIT_DMA_FLAG;
        end else if (i_reg.addr == `RDB_OFF_MISSED) begin
            o_rdata <= missed_frame_counter;
        end else if (i_reg.addr == `RDB_OFF_DMA_SOF) begin
            o_rdata <= start_offset;
        end else if (i_reg.addr == `RDB_OFF_DMA_FCNT) begin
            o_rdata <= frame_count;
        end else if (i_reg.addr == `RDB_OFF_DMA_BCNT) begin
            o_rdata <= byte_count;
        end else begin
            o_rdata <= 16'h0000;
        end
    end
endmodule // rdb_rx_dma_ctrl

// file: testbench/rdb_host_dma_model.sv
/*
 Model of the system DMA channel that empties the on-chip receive buffer.
 Assumes the bench pulses i_add once per frame held on chip.
*/
`timescale 1ns/100ps
module rdb_host_dma_model (
    // Clock, reset and control
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_dma_active,
    input wire logic i_add,
    input wire logic i_slow,
    // Mover status
    output logic o_dma_busy,
    output logic o_frame_done,
    output logic o_buffered,
    output logic [15:0] o_frame_len
);
    int held;
    int left;
    logic last;
    assign last = o_dma_busy && left == 0;
    assign o_buffered = held != 0;
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            held <= 0;
            left <= 0;
            o_dma_busy <= 1'b0;
            o_frame_done <= 1'b0;
            o_frame_len <= 16'h0000;
        end else begin
            held <= held + int'(i_add) - int'(last);
            o_frame_done <= last;
            // Done only once the whole frame is moved
            if (last) begin
                o_dma_busy <= 1'b0;
            end else if (o_dma_busy) begin
                left <= left - 1;
            end else if (i_dma_active && held != 0) begin
                // Slow channel keeps the buffer full longer
                o_dma_busy <= 1'b1;
                left <= i_slow ? 40 : 3;
                o_frame_len <= 16'h0040 + 16'(held);
            end
        end
    end
endmodule // rdb_host_dma_model

// file: testbench/rdb_rx_dma_ctrl_asserts.sv
/*
 Port checker for the receive DMA controller.
 Assumes a register write takes effect on the next cycle.
*/
`timescale 1ns/100ps
`include "rdb_map.svh"
module rdb_rx_dma_ctrl_asserts
    import rdb_pkg::*;
(
    // Block inputs
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input rdb_reg_req_s i_reg,
    input wire logic i_frame_end,
    input rdb_frame_s i_frame,
    input wire logic i_frame_missed,
    input wire logic i_reports_pending,
    input wire logic i_dma_frame_done,
    input wire logic i_dma_busy,
    // Block outputs
    input wire logic o_dma_active,
    input wire logic o_free_oldest,
    input wire logic o_discard_rx_reports,
    input wire logic o_drop_missed_reports,
    input wire logic o_dma_irq,
    input wire logic o_pio_frame
);
    logic [15:0] cfg;
    logic [15:0] bcfg;
    logic pio;
    logic quiet;
    assign pio = !cfg[`RDB_BIT_DMA_ONLY] && !cfg[`RDB_BIT_AUTO_DMA];
    // Burst exit may raise the DMA irq, so bursts are left out
    assign quiet = cfg[`RDB_BIT_DMA_ONLY] && !cfg[`RDB_BIT_BURST_EN]
        && !bcfg[`RDB_BIT_DMA_IE];
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            cfg <= `RDB_RST_CFG;
        end else if (i_reg.wr && i_reg.addr == `RDB_OFF_RX_CFG) begin
            cfg <= i_reg.wdata;
        end
    end
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            bcfg <= `RDB_RST_CFG;
        end else if (i_reg.wr && i_reg.addr == `RDB_OFF_BUF_CFG) begin
            bcfg <= i_reg.wdata;
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    sequence pio_good_end;
        pio && i_frame_end && i_frame.good && i_frame.addr_pass;
    endsequence
    sequence pio_idle;
        pio && !o_dma_active;
    endsequence
    chk_free_after_done: assert property (
        o_free_oldest |-> $past(i_dma_frame_done))
        else $error("buffer freed without finished frame");
    chk_missed_drop: assert property (
        i_frame_missed |-> ##[1:2] o_drop_missed_reports)
        else $error("missed frame reports kept");
    chk_dma_stays: assert property (
        o_dma_active && (i_dma_busy || i_reports_pending) |=> o_dma_active)
        else $error("dma left too early");
    chk_pio_no_dma: assert property (
        pio_idle |=> !o_dma_active)
        else $error("dma entered in pio mode");
    chk_pio_frame_out: assert property (
        pio_good_end |-> ##[1:2] o_pio_frame)
        else $error("pio frame not delivered");
    chk_discard_start: assert property (
        o_discard_rx_reports |-> ##[0:1] o_dma_active)
        else $error("reports dropped outside dma");
    chk_dma_only_nopio: assert property (
        cfg[`RDB_BIT_DMA_ONLY] |-> !o_pio_frame)
        else $error("pio frame in dma only mode");
    chk_dma_irq_gated: assert property (
        quiet |-> !o_dma_irq)
        else $error("dma irq while disabled");
endmodule // rdb_rx_dma_ctrl_asserts
bind rdb_rx_dma_ctrl rdb_rx_dma_ctrl_asserts u_rdb_rx_dma_ctrl_asserts (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_reg(i_reg),
    .i_frame_end(i_frame_end), .i_frame(i_frame),
    .i_frame_missed(i_frame_missed), .i_reports_pending(i_reports_pending),
    .i_dma_frame_done(i_dma_frame_done), .i_dma_busy(i_dma_busy),
    .o_dma_active(o_dma_active), .o_free_oldest(o_free_oldest),
    .o_discard_rx_reports(o_discard_rx_reports),
    .o_drop_missed_reports(o_drop_missed_reports),
    .o_dma_irq(o_dma_irq), .o_pio_frame(o_pio_frame));

// file: testbench/rdb_rx_dma_ctrl_bench.sv
/*
 Self-checking bench for the receive DMA controller.
 Assumes the DMA model answers for the host side.
*/
`timescale 1ns/100ps
`include "rdb_map.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    error_cnt++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
    end end
module rdb_rx_dma_ctrl_bench
    import rdb_pkg::*;
;
    logic i_clock = 1'b0;
    logic i_sys_rst, i_frame_end, i_frame_start, i_start_addr_pass;
    logic i_frame_missed, i_space_low, i_reports_pending, keep, slow;
    logic busy, done, held, o_dma_active, o_free_oldest, o_pio_frame;
    logic o_discard_rx_reports, o_drop_missed_reports, o_good_irq, o_dma_irq;
    logic [15:0] o_rdata, len;
    rdb_reg_req_s i_reg;
    rdb_frame_s i_frame;
    int seed, error_cnt = 0, samples_checked = 0;
    int n_good = 0, n_dma = 0, n_pio = 0, n_disc = 0, n_free = 0;
    always #4 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        n_good <= n_good + int'(o_good_irq);
        n_dma <= n_dma + int'(o_dma_irq);
        n_pio <= n_pio + int'(o_pio_frame);
        n_disc <= n_disc + int'(o_discard_rx_reports);
        n_free <= n_free + int'(o_free_oldest);
    end
    rdb_rx_dma_ctrl u_rdb_rx_dma_ctrl (.i_clock(i_clock),
        .i_sys_rst(i_sys_rst), .i_reg(i_reg), .o_rdata(o_rdata),
        .i_frame_end(i_frame_end), .i_frame(i_frame),
        .i_frame_start(i_frame_start), .i_start_addr_pass(i_start_addr_pass),
        .i_frame_missed(i_frame_missed), .i_space_low(i_space_low),
        .i_frames_buffered(held), .i_reports_pending(i_reports_pending),
        .i_dma_frame_done(done), .i_dma_frame_len(len), .i_dma_busy(busy),
        .o_dma_active(o_dma_active), .o_free_oldest(o_free_oldest),
        .o_discard_rx_reports(o_discard_rx_reports),
        .o_drop_missed_reports(o_drop_missed_reports),
        .o_good_irq(o_good_irq), .o_dma_irq(o_dma_irq),
        .o_pio_frame(o_pio_frame));
    rdb_host_dma_model u_rdb_host_dma_model (.i_clock(i_clock),
        .i_sys_rst(i_sys_rst), .i_dma_active(o_dma_active),
        .i_add(i_frame_end && keep), .i_slow(slow), .o_dma_busy(busy),
        .o_frame_done(done), .o_buffered(held), .o_frame_len(len));
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_reg <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge i_clock);
        i_reg <= '0;
    endtask
    task automatic reg_rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge i_clock);
        i_reg <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(posedge i_clock);
        i_reg <= '0;
        #1 d = o_rdata;
    endtask
    task automatic send(input logic good, input int gap);
        tick(gap);
        i_frame_start <= 1'b1;
        i_start_addr_pass <= 1'b1;
        @(posedge i_clock);
        i_frame_start <= 1'b0;
        i_frame_end <= 1'b1;
        i_frame <= '{addr_pass: 1'b1, good: good,
            length: 16'h0040 + 16'($random(seed) & 16'h03ff)};
        @(posedge i_clock);
        i_frame_end <= 1'b0;
    endtask
    task automatic wait_act(input logic v);
        int k;
        for (k = 0; k < 3000 && o_dma_active !== v; k++) begin
            @(posedge i_clock);
            #1;
        end
        if (o_dma_active !== v) begin
            `CHK(o_dma_active, v)
            test_done();
        end
    endtask
    task automatic drain();
        int k;
        for (k = 0; k < 3000 && (held !== 1'b0 || busy !== 1'b0); k++) begin
            @(posedge i_clock);
            #1;
        end
        `CHK({held, busy}, 2'b00)
        if (held !== 1'b0 || busy !== 1'b0) test_done();
        tick(20);
    endtask
    task automatic test_done();
        $display("samples %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        logic [15:0] v;
        int n, i, g, d;
        seed = 7048;
        {i_sys_rst, i_frame_end, i_frame_start, i_start_addr_pass} = 4'h1;
        {i_frame_missed, i_space_low, i_reports_pending, keep} = 4'h0;
        slow = 1'b0;
        i_reg = '0;
        i_frame = '0;
        tick(4);
        i_sys_rst <= 1'b0;
        reg_rd(`RDB_OFF_RX_CFG, v);
        `CHK(v, `RDB_RST_CFG)
        reg_rd(16'h0200, v);
        `CHK(v, 16'h0000)
        n = n_pio;
        for (i = 0; i < 3; i++) send(1'b1, 2000);
        tick(3);
        `CHK(n_pio - n, 3)
        $display("pio mode test ended");
        n = 1 + ($random(seed) & 3);
        for (i = 0; i < n; i++) begin
            @(posedge i_clock) i_frame_missed <= 1'b1;
            @(posedge i_clock) i_frame_missed <= 1'b0;
        end
        reg_rd(`RDB_OFF_MISSED, v);
        `CHK(v, 16'(n))
        reg_rd(`RDB_OFF_MISSED, v);
        `CHK(v, 16'h0000)
        $display("missed frame test ended");
        reg_wr(`RDB_OFF_RX_CFG, 16'h0400);
        {keep, slow, i_reports_pending} <= {2'b11, 1'($random(seed))};
        for (i = 0; i < 2; i++) send(1'b1, 7000);
        d = n_disc;
        i_space_low <= 1'b1;
        @(posedge i_clock) i_frame_start <= 1'b1;
        @(posedge i_clock) i_frame_start <= 1'b0;
        wait_act(1'b1);
        drain();
        `CHK(n_disc - d, 1)
        `CHK(n_free, 2)
        reg_rd(`RDB_OFF_DMA_FCNT, v);
        `CHK(v, 16'h0002)
        tick(5);
        `CHK(o_dma_active, 1'b1)
        {i_reports_pending, i_space_low} <= 2'b00;
        reg_rd(`RDB_OFF_DMA_FCNT, v);
        `CHK(v, 16'h0000)
        wait_act(1'b0);
        $display("auto switch test ended");
        reg_wr(`RDB_OFF_RX_CFG, 16'h0580);
        reg_wr(`RDB_OFF_RX_CTL, 16'h0100);
        reg_wr(`RDB_OFF_BUF_CFG, 16'h0080);
        {g, d} = {n_good, n_dma};
        for (i = 0; i < 9; i++) begin
            // Lone first frame, then eight inside the spacing window
            send(1'b1, (i == 0) ? 7000 : 1300 + ($random(seed) & 4095));
        end
        tick(100);
        `CHK(n_good - g, 0)
        `CHK(n_dma > d, 1'b1)
        reg_rd(`RDB_OFF_BUF_EVENT, v);
        `CHK(v[`RDB_BIT_DMA_FLAG], 1'b1)
        reg_rd(`RDB_OFF_BUF_EVENT, v);
        `CHK(v[`RDB_BIT_DMA_FLAG], 1'b1)
        reg_rd(`RDB_OFF_DMA_FCNT, v);
        `CHK(v != 16'h0000 && v <= 16'h0008, 1'b1)
        reg_rd(`RDB_OFF_BUF_EVENT, v);
        `CHK(v[`RDB_BIT_DMA_FLAG], 1'b0)
        d = n_dma;
        send(1'b0, 1500);
        for (i = 0; i < 300 && n_good == g; i++) tick(1);
        tick(3);
        `CHK({n_good > g, n_dma > d}, 2'b11)
        if (n_good == g) test_done();
        drain();
        reg_rd(`RDB_OFF_DMA_FCNT, v);
        reg_rd(`RDB_OFF_DMA_FCNT, v);
        `CHK(v, 16'h0000)
        wait_act(1'b0);
        $display("burst test ended");
        reg_wr(`RDB_OFF_BUF_CFG, 16'h0000);
        reg_wr(`RDB_OFF_RX_CFG, 16'h0200);
        d = n_dma;
        send(1'b1, 7000);
        wait_act(1'b1);
        drain();
        `CHK(n_dma - d, 0)
        $display("dma only test ended");
        test_done();
    end
endmodule // rdb_rx_dma_ctrl_bench
